//--- pkg/eep_pkg.sv
package eep_pkg;

	// Link word geometry for the two organisations
	localparam int BYTE_ADDR_W = 9;
	localparam int WORD_ADDR_W = 8;
	localparam int BYTE_DATA_W = 8;
	localparam int WORD_DATA_W = 16;
	localparam int ADDR_W_MAX  = 9;
	localparam int DATA_W_MAX  = 16;
	localparam int CNT_W       = 5;
	localparam int TIMER_W     = 20;

	// Opcode field after the start marker
	localparam logic [1:0] OPC_ERASE   = 2'h3;
	localparam logic [1:0] OPC_READ    = 2'h2;
	localparam logic [1:0] OPC_WRITE   = 2'h1;
	localparam logic [1:0] OPC_SPECIAL = 2'h0;

	// Top two address bits under the special opcode
	localparam logic [1:0] SPC_WIPE   = 2'h2;
	localparam logic [1:0] SPC_LOCK   = 2'h0;
	localparam logic [1:0] SPC_UNLOCK = 2'h3;
	localparam logic [1:0] SPC_FILL   = 2'h1;

	// Self-timed cycle lengths, longest figures, so rounded down
	localparam int REF_CLK_HZ     = 50000000;
	localparam int CELL_CYCLE_MS  = 6;
	localparam int WIPE_CYCLE_MS  = 6;
	localparam int FILL_CYCLE_MS  = 15;
	localparam int CELL_CYCLES    = CELL_CYCLE_MS * (REF_CLK_HZ / 1000);
	localparam int WIPE_CYCLES    = WIPE_CYCLE_MS * (REF_CLK_HZ / 1000);
	localparam int FILL_CYCLES    = FILL_CYCLE_MS * (REF_CLK_HZ / 1000);

	typedef enum logic [2:0] {
		OP_NONE   = 3'h0,
		OP_ERASE  = 3'h1,
		OP_READ   = 3'h2,
		OP_WRITE  = 3'h3,
		OP_WIPE   = 3'h4,
		OP_LOCK   = 3'h5,
		OP_UNLOCK = 3'h6,
		OP_FILL   = 3'h7
	} eep_op_t;

	typedef enum logic [2:0] {
		LK_IDLE = 3'h0,
		LK_OPC  = 3'h1,
		LK_ADDR = 3'h2,
		LK_DATA = 3'h3,
		LK_READ = 3'h4,
		LK_DONE = 3'h5
	} eep_lk_state_t;

	typedef struct packed {
		eep_op_t                 op;
		logic [ADDR_W_MAX-1:0]   addr;
		logic [DATA_W_MAX-1:0]   data;
	} eep_cmd_t;

endpackage

//--- hw/eep_sync.sv
`timescale 1ns/1ps
module eep_sync (
	input  wire logic ref_clk,
	input  wire logic resetn,
	input  wire logic d,
	output logic      q
);
	logic meta_r;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			meta_r <= 1'b0;
			q      <= 1'b0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

//--- hw/eep_prog_timer.sv
`timescale 1ns/1ps
module eep_prog_timer (
	input  wire logic                        ref_clk,
	input  wire logic                        resetn,
	input  wire logic                        start,
	input  wire logic [eep_pkg::TIMER_W-1:0] load,
	output logic                             busy,
	output logic                             done
);
	import eep_pkg::*;

	logic [TIMER_W-1:0] cnt_r;

	// Runs on the system clock alone, the link clock may be stopped
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			cnt_r <= '0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				cnt_r <= load;
				busy  <= 1'b1;
			end else if (busy) begin
				if (cnt_r <= TIMER_W'(1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
				cnt_r <= cnt_r - TIMER_W'(1);
			end
		end
	end
endmodule

//--- hw/eep_cmd_port.sv
`timescale 1ns/1ps
// How it works
// - Select high means selected; a running program cycle still finishes.
// - Select low holds the decode logic in reset.
// - Input bits sampled and read bits shifted on rising link edges.
// - Link clock may stop anywhere; partial instructions are kept.
// - Link clock ignored when deselected; idle clocks wait for start.
// - Start marker is first rising edge with select and input high.
// - Byte layout: 12 edges for short commands, 20 with data.
// - Word layout: 11 edges for short commands, 27 with data.
// - After the last bit, clock and input are ignored until select falls.
// - Special: 10 wipe_all, 00 lock, 11 unlock, 01 fill_all.
// - Address nine bits byte, eight bits word, MSB first.
// - Output floats except read or status; floats on select fall.
// - Status low while programming, high once ready.
// - Status shown only if select rises during the cycle.
// - A zero bit precedes read data, on the last address edge.
// - Erase starts at select fall and sets the location to ones.
// - Wipe_all sets the whole array to ones, no clocks needed.
// - Self-timed cycles need no link clock once started.
// - Power-up locked; erase and write refused until unlocked.
// - Unlock holds until lock or power loss.
// - Reads work whether locked or unlocked.
// - Write: data after address, select fall erases then programs.
// - Select held high after a read word streams the next address.
// - Fill_all writes every location, only when unlocked.
module eep_cmd_port #(
	parameter bit WORD_ORG    = 1'b0,
	parameter int CELL_CYCLES = eep_pkg::CELL_CYCLES,
	parameter int WIPE_CYCLES = eep_pkg::WIPE_CYCLES,
	parameter int FILL_CYCLES = eep_pkg::FILL_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic resetn,
	input  wire logic link_clk,
	input  wire logic select,
	input  wire logic serial_in,
	output logic      serial_out,
	output logic      serial_out_oe,
	output logic      ready_busy_flag,
	output logic      program_locked,
	output logic      standby
);
	import eep_pkg::*;

	localparam int AW    = WORD_ORG ? WORD_ADDR_W : BYTE_ADDR_W;
	localparam int DW    = WORD_ORG ? WORD_DATA_W : BYTE_DATA_W;
	localparam int DEPTH = 1 << AW;
	localparam logic [CNT_W-1:0] ADDR_LAST = CNT_W'(AW - 1);
	localparam logic [CNT_W-1:0] DATA_LAST = CNT_W'(DW - 1);
	localparam logic [ADDR_W_MAX-1:0] ADDR_MASK =
		ADDR_W_MAX'((1 << AW) - 1);
	localparam logic [DATA_W_MAX-1:0] DATA_MASK =
		DATA_W_MAX'((1 << DW) - 1);

	function automatic eep_op_t decode_op(
		input logic [1:0]            opc,
		input logic [ADDR_W_MAX-1:0] addr
	);
		logic [1:0] spc;
		spc = {addr[AW-1], addr[AW-2]};
		unique case (opc)
			OPC_ERASE: decode_op = OP_ERASE;
			OPC_READ:  decode_op = OP_READ;
			OPC_WRITE: decode_op = OP_WRITE;
			OPC_SPECIAL: begin
				unique case (spc)
					SPC_WIPE:   decode_op = OP_WIPE;
					SPC_LOCK:   decode_op = OP_LOCK;
					SPC_UNLOCK: decode_op = OP_UNLOCK;
					SPC_FILL:   decode_op = OP_FILL;
				endcase
			end
		endcase
	endfunction

	function automatic logic [TIMER_W-1:0] cycles_for(input eep_op_t op);
		unique case (op)
			OP_WIPE: cycles_for = TIMER_W'(WIPE_CYCLES);
			OP_FILL: cycles_for = TIMER_W'(FILL_CYCLES);
			default: cycles_for = TIMER_W'(CELL_CYCLES);
		endcase
	endfunction

	// Array is written only by the system domain, read by the link
	// domain; a read issued while a program cycle runs sees stale data
	logic [DATA_W_MAX-1:0] mem [0:DEPTH-1];

	// ---------------- Link domain ----------------
	logic                  lk_rst_n_r;
	logic                  lk_clr_n;
	eep_lk_state_t         state_r;
	logic [CNT_W-1:0]      cnt_r;
	logic [1:0]            opc_r;
	eep_op_t               op_r;
	logic [ADDR_W_MAX-1:0] addr_sh_r;
	logic [DATA_W_MAX-1:0] data_sh_r;
	logic [DATA_W_MAX-1:0] rd_word_r;
	logic                  rd_bit_r;
	logic                  rd_oe_r;
	eep_cmd_t              cmd_r;
	logic                  cmd_tgl_r;
	logic [ADDR_W_MAX-1:0] addr_nxt;
	logic [DATA_W_MAX-1:0] data_nxt;
	logic [DATA_W_MAX-1:0] mem_word;
	eep_op_t               op_nxt;
	logic                  addr_end;
	logic                  data_end;
	logic                  issue;

	// Deselect clears the decoder at once, whether or not the link
	// clock is running
	assign lk_clr_n = select & lk_rst_n_r;

	assign addr_nxt = {addr_sh_r[ADDR_W_MAX-2:0], serial_in} & ADDR_MASK;
	assign data_nxt = {data_sh_r[DATA_W_MAX-2:0], serial_in} & DATA_MASK;
	assign op_nxt   = decode_op(opc_r, addr_nxt);
	assign mem_word = mem[addr_sh_r[AW-1:0]];
	assign addr_end = (state_r == LK_ADDR) && (cnt_r == ADDR_LAST);
	assign data_end = (state_r == LK_DATA) && (cnt_r == DATA_LAST);
	assign issue    = (addr_end && op_nxt != OP_READ && op_nxt != OP_WRITE
		&& op_nxt != OP_FILL) || data_end;

	// State moves only on link edges or deselect, so a stopped clock just pauses it
	always_ff @(posedge link_clk or negedge lk_clr_n) begin
		if (!lk_clr_n) begin
			state_r <= LK_IDLE;
			cnt_r   <= '0;
			opc_r   <= '0;
			op_r    <= OP_NONE;
		end else begin
			unique case (state_r)
				LK_IDLE: begin
					// Clocks with input low are accepted and change nothing
					if (serial_in) begin
						state_r <= LK_OPC;
					end
					cnt_r <= '0;
				end
				LK_OPC: begin
					opc_r <= {opc_r[0], serial_in};
					if (cnt_r == CNT_W'(1)) begin
						state_r <= LK_ADDR;
						cnt_r   <= '0;
					end else begin
						cnt_r <= cnt_r + CNT_W'(1);
					end
				end
				LK_ADDR: begin
					if (addr_end) begin
						op_r  <= op_nxt;
						cnt_r <= '0;
						if (op_nxt == OP_READ) begin
							state_r <= LK_READ;
						end else if (op_nxt == OP_WRITE || op_nxt == OP_FILL) begin
							state_r <= LK_DATA;
						end else begin
							state_r <= LK_DONE;
						end
					end else begin
						cnt_r <= cnt_r + CNT_W'(1);
					end
				end
				LK_DATA: begin
					if (data_end) begin
						state_r <= LK_DONE;
						cnt_r   <= '0;
					end else begin
						cnt_r <= cnt_r + CNT_W'(1);
					end
				end
				LK_READ: begin
					// Sequential read keeps going while select stays high
					if (cnt_r == DATA_LAST) begin
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + CNT_W'(1);
					end
				end
				LK_DONE: begin
					state_r <= LK_DONE;
				end
				default: begin
					state_r <= LK_IDLE;
				end
			endcase
		end
	end

	// Shift registers for address and data, MSB first
	always_ff @(posedge link_clk or negedge lk_clr_n) begin
		if (!lk_clr_n) begin
			addr_sh_r <= '0;
			data_sh_r <= '0;
		end else begin
			if (state_r == LK_ADDR) begin
				addr_sh_r <= addr_nxt;
			end else if (state_r == LK_READ && cnt_r == DATA_LAST) begin
				addr_sh_r <= (addr_sh_r + ADDR_W_MAX'(1)) & ADDR_MASK;
			end
			if (state_r == LK_DATA) begin
				data_sh_r <= data_nxt;
			end
		end
	end

	// Read output: dummy zero on the last address edge, then the word
	always_ff @(posedge link_clk or negedge lk_clr_n) begin
		if (!lk_clr_n) begin
			rd_oe_r   <= 1'b0;
			rd_bit_r  <= 1'b0;
			rd_word_r <= '0;
		end else if (addr_end && op_nxt == OP_READ) begin
			rd_oe_r  <= 1'b1;
			rd_bit_r <= 1'b0;
		end else if (state_r == LK_READ) begin
			if (cnt_r == '0) begin
				rd_bit_r  <= mem_word[DW-1];
				rd_word_r <= mem_word << 1;
			end else begin
				rd_bit_r  <= rd_word_r[DW-1];
				rd_word_r <= rd_word_r << 1;
			end
		end
	end

	// Command hand-off survives deselect; toggle and command clear only on system reset
	always_ff @(posedge link_clk or negedge lk_rst_n_r) begin
		if (!lk_rst_n_r) begin
			cmd_tgl_r <= 1'b0;
			cmd_r     <= '0;
		end else if (issue) begin
			cmd_tgl_r  <= ~cmd_tgl_r;
			cmd_r.op   <= addr_end ? op_nxt : op_r;
			cmd_r.addr <= addr_end ? addr_nxt : addr_sh_r;
			cmd_r.data <= data_end ? data_nxt : '0;
		end
	end

	// ---------------- System domain ----------------
	logic     sel_s;
	logic     sel_d_r;
	logic     tgl_s;
	logic     tgl_d_r;
	logic     sel_rise;
	logic     sel_fall;
	logic     tgl_ev;
	logic     go_r;
	logic     locked_r;
	logic     pend_r;
	eep_cmd_t pend_cmd_r;
	eep_cmd_t run_cmd_r;
	logic     start;
	logic     busy;
	logic     done;
	logic     armed_r;
	logic     status_en_r;

	eep_sync u_sel_sync (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.d       (select),
		.q       (sel_s)
	);

	eep_sync u_tgl_sync (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.d       (cmd_tgl_r),
		.q       (tgl_s)
	);

	eep_prog_timer u_timer (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.start   (start),
		.load    (cycles_for(pend_cmd_r.op)),
		.busy    (busy),
		.done    (done)
	);

	assign sel_rise = sel_s & ~sel_d_r;
	assign sel_fall = ~sel_s & sel_d_r;
	assign tgl_ev   = tgl_s ^ tgl_d_r;
	assign start    = go_r & pend_r & ~busy;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			lk_rst_n_r <= 1'b0;
			sel_d_r    <= 1'b0;
			tgl_d_r    <= 1'b0;
			go_r       <= 1'b0;
		end else begin
			lk_rst_n_r <= 1'b1;
			sel_d_r    <= sel_s;
			tgl_d_r    <= tgl_s;
			// One cycle late so a command and the fall seen together
			// are ordered
			go_r       <= sel_fall;
		end
	end

	// Lock state; power-up is locked
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			locked_r <= 1'b1;
		end else if (tgl_ev && cmd_r.op == OP_LOCK) begin
			locked_r <= 1'b1;
		end else if (tgl_ev && cmd_r.op == OP_UNLOCK) begin
			locked_r <= 1'b0;
		end
	end

	// Program commands wait here for the select fall
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pend_r     <= 1'b0;
			pend_cmd_r <= '0;
		end else if (tgl_ev && !locked_r && !busy && cmd_r.op != OP_LOCK
			&& cmd_r.op != OP_UNLOCK) begin
			pend_r     <= 1'b1;
			pend_cmd_r <= cmd_r;
		end else if (start || sel_rise) begin
			pend_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			run_cmd_r <= '0;
		end else if (start) begin
			run_cmd_r <= pend_cmd_r;
		end
	end

	// Array update at the end of the self-timed cycle
	always_ff @(posedge ref_clk) begin
		if (done) begin
			unique case (run_cmd_r.op)
				OP_ERASE: mem[run_cmd_r.addr[AW-1:0]] <= DATA_MASK;
				OP_WRITE: mem[run_cmd_r.addr[AW-1:0]] <= run_cmd_r.data;
				OP_WIPE: begin
					for (int i = 0; i < DEPTH; i++) begin
						mem[i] <= DATA_MASK;
					end
				end
				OP_FILL: begin
					for (int i = 0; i < DEPTH; i++) begin
						mem[i] <= run_cmd_r.data;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Status offered only if select rises while the cycle is still owed
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			armed_r     <= 1'b0;
			status_en_r <= 1'b0;
		end else begin
			if (start) begin
				armed_r <= 1'b1;
			end else if (sel_rise && armed_r) begin
				armed_r <= 1'b0;
			end else if (!busy && !sel_s) begin
				armed_r <= 1'b0;
			end
			if (sel_rise && armed_r) begin
				status_en_r <= 1'b1;
			end else if (sel_fall) begin
				status_en_r <= 1'b0;
			end
		end
	end

	// Raw select gates the enable so the pin floats as select drops
	assign serial_out_oe   = select & (status_en_r | rd_oe_r);
	assign serial_out      = status_en_r ? ~busy : rd_bit_r;
	assign ready_busy_flag = ~busy;
	assign program_locked  = locked_r;
	assign standby         = ~sel_s & ~busy;

endmodule

//--- test/eep_cmd_monitor.sv
`timescale 1ns/1ps
module eep_cmd_monitor #(
	parameter int FILL_CYCLES = 120
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic select,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic ready_busy_flag,
	input wire logic program_locked,
	input wire logic standby
);
	// Longest cycle plus select sync and launch slack
	localparam int MAX_BUSY = FILL_CYCLES + 16;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	oe_sel_a: assert property (
		serial_out_oe |-> select)
		else $error("output driven while deselected");
	lock_boot_a: assert property (
		$rose(resetn) |-> program_locked)
		else $error("not locked after reset");
	lock_refuse_a: assert property (
		(program_locked && ready_busy_flag) |=> ready_busy_flag)
		else $error("program cycle while locked");
	busy_standby_a: assert property (
		!ready_busy_flag |-> !standby)
		else $error("standby during program cycle");
	idle_standby_a: assert property (
		(!select && ready_busy_flag) [*5] |-> standby)
		else $error("no standby when idle and deselected");
	sel_wake_a: assert property (
		select [*4] |-> !standby)
		else $error("standby while selected");
	status_lvl_a: assert property (
		(serial_out_oe && !ready_busy_flag) |-> !serial_out)
		else $error("status high while busy");
	busy_start_a: assert property (
		$fell(ready_busy_flag) |-> !select)
		else $error("cycle started while selected");
	busy_bound_a: assert property (
		$fell(ready_busy_flag) |-> ##[1:MAX_BUSY] ready_busy_flag)
		else $error("program cycle never ends");
	busy_min_a: assert property (
		$fell(ready_busy_flag) |-> !ready_busy_flag [*8])
		else $error("program cycle too short");
	cover property ($fell(ready_busy_flag));
	cover property (serial_out_oe && serial_out);
	cover property ($fell(program_locked));
endmodule

bind eep_cmd_port eep_cmd_monitor #(.FILL_CYCLES(FILL_CYCLES)) u_eep_cmd_monitor (
	.ref_clk        (ref_clk),
	.resetn         (resetn),
	.select         (select),
	.serial_out     (serial_out),
	.serial_out_oe  (serial_out_oe),
	.ready_busy_flag(ready_busy_flag),
	.program_locked (program_locked),
	.standby        (standby)
);

//--- test/eep_link_master.sv
`timescale 1ns/1ps
module eep_link_master (
	input  wire logic ref_clk,
	input  wire logic serial_out,
	output logic      link_clk,
	output logic      select,
	output logic      serial_in
);
	initial begin
		link_clk = 1'b0;
		select = 1'b0;
		serial_in = 1'b0;
	end
	// Low time between frames and setup before the first edge
	task automatic sel(input logic v);
		@(negedge ref_clk);
		select = v;
		if (!v) begin
			serial_in = ~serial_in; // Released line shows no stale level
		end
		#(v ? 100 : 300);
	endtask
	// Clock stands low outside frames; read bit sampled mid-period
	task automatic shift(input logic [31:0] bits, input int n,
		output logic [31:0] got);
		got = '0;
		#7;
		for (int i = n - 1; i >= 0; i--) begin
			serial_in = bits[i];
			#40 link_clk = 1'b1;
			#40 link_clk = 1'b0;
			got = {got[30:0], serial_out};
		end
	endtask
endmodule

//--- test/test_serial_eeprom_command_port.sv
`timescale 1ns/1ps
module test_serial_eeprom_command_port;
	import eep_pkg::*;
	logic ref_clk, resetn, link_clk, select, serial_in;
	logic serial_out, serial_out_oe, ready_busy_flag, program_locked, standby;
	int   n_errors = 0;
	int   n_tests  = 0;

	eep_cmd_port #(.WORD_ORG(1'b0), .CELL_CYCLES(60), .WIPE_CYCLES(60),
		.FILL_CYCLES(120)) u_eep_cmd_port (
		.ref_clk        (ref_clk),
		.resetn         (resetn),
		.link_clk       (link_clk),
		.select         (select),
		.serial_in      (serial_in),
		.serial_out     (serial_out),
		.serial_out_oe  (serial_out_oe),
		.ready_busy_flag(ready_busy_flag),
		.program_locked (program_locked),
		.standby        (standby)
	);
	eep_link_master u_eep_link_master (
		.ref_clk   (ref_clk),
		.serial_out(serial_out),
		.link_clk  (link_clk),
		.select    (select),
		.serial_in (serial_in)
	);

	task automatic chk(input string what, input logic [15:0] exp, got);
		n_tests++;
		if (exp !== got) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_sim();
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Data form: start, opcode, address, data, then four stray clocks
	task automatic wr(input logic [1:0] o, input logic [8:0] a,
		input logic [7:0] d);
		logic [31:0] g;
		u_eep_link_master.sel(1'b1);
		u_eep_link_master.shift({8'h0, 1'b1, o, a, d, 4'hF}, 24,
			g);
		u_eep_link_master.sel(1'b0);
	endtask
	task automatic sh(input logic [1:0] o, input logic [8:0] a);
		logic [31:0] g;
		u_eep_link_master.sel(1'b1);
		u_eep_link_master.shift({20'h0, 1'b1, o, a}, 12, g);
		u_eep_link_master.sel(1'b0);
	endtask
	// Idle clocks lead, and the clock halts mid-address
	task automatic rd(input logic [8:0] a, input logic [15:0] exp);
		logic [31:0] g;
		u_eep_link_master.sel(1'b1);
		u_eep_link_master.shift({25'h0, 1'b1, OPC_READ, a[8:5]}, 10,
			g);
		#1000;
		u_eep_link_master.shift({11'h0, a[4:0], 16'h0}, 21,
			g);
		chk("dummy", 16'h0000, 16'(g[16]));
		chk("read", exp, g[15:0]);
		chk("oe read", 16'h0001, 16'(serial_out_oe));
		u_eep_link_master.sel(1'b0);
		chk("oe idle", 16'h0000, 16'(serial_out_oe));
	endtask
	task automatic done();
		int k;
		k = 0;
		chk("busy", 16'h0000, 16'(ready_busy_flag));
		while (ready_busy_flag !== 1'b1 && k < 500) begin
			@(negedge ref_clk);
			k++;
		end
		chk("ready", 16'h0001, 16'(ready_busy_flag));
	endtask
	task automatic t_locked();
		chk("locked", 16'h0001, 16'(program_locked));
		wr(OPC_WRITE, 9'h1FE, 8'h00);
		chk("refused", 16'h0001, 16'(ready_busy_flag));
		sh(OPC_SPECIAL, {SPC_UNLOCK, 7'h0});
		u_eep_link_master.sel(1'b1);
		chk("unlocked", 16'h0000, 16'(program_locked));
		chk("oe unlock", 16'h0000, 16'(serial_out_oe));
		u_eep_link_master.sel(1'b0);
	endtask
	task automatic t_write();
		wr(OPC_WRITE, 9'h1FE, 8'h3C);
		u_eep_link_master.sel(1'b1);
		chk("oe status", 16'h0001, 16'(serial_out_oe));
		chk("status busy", 16'h0000, 16'(serial_out));
		done();
		chk("status ready", 16'h0001, 16'(serial_out));
		u_eep_link_master.sel(1'b0);
		chk("oe fall", 16'h0000, 16'(serial_out_oe));
		wr(OPC_WRITE, 9'h1FF, 8'hA5);
		done();
		// Select rises after the cycle ended: no status is owed
		u_eep_link_master.sel(1'b1);
		chk("oe held low", 16'h0000, 16'(serial_out_oe));
		u_eep_link_master.sel(1'b0);
		rd(9'h1FE, 16'h3CA5);
	endtask
	task automatic t_abort();
		logic [31:0] g;
		u_eep_link_master.sel(1'b1);
		u_eep_link_master.shift({24'h0, 1'b1, OPC_WRITE, 5'h1F}, 8, g);
		u_eep_link_master.sel(1'b0);
		chk("aborted", 16'h0001, 16'(ready_busy_flag));
		rd(9'h1FE, 16'h3CA5);
	endtask
	task automatic t_erase_lock();
		sh(OPC_ERASE, 9'h1FE);
		done();
		rd(9'h1FE, 16'hFFA5);
		sh(OPC_SPECIAL, {SPC_LOCK, 7'h0});
		chk("relocked", 16'h0001, 16'(program_locked));
		wr(OPC_WRITE, 9'h1FF, 8'h00);
		chk("lock refuse", 16'h0001, 16'(ready_busy_flag));
		rd(9'h1FE, 16'hFFA5);
	endtask
	task automatic t_array();
		sh(OPC_SPECIAL, {SPC_UNLOCK, 7'h0});
		sh(OPC_SPECIAL, {SPC_WIPE, 7'h0});
		done();
		rd(9'h1FE, 16'hFFFF);
		wr(OPC_SPECIAL, {SPC_FILL, 7'h0}, 8'h5A);
		done();
		rd(9'h000, 16'h5A5A);
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial begin
		#400000;
		n_errors++;
		end_sim();
	end
	initial begin
		resetn = 1'b0;
		repeat (8) @(negedge ref_clk);
		resetn = 1'b1;
		repeat (4) @(negedge ref_clk);
		t_locked();
		t_write();
		t_abort();
		t_erase_lock();
		t_array();
		end_sim();
	end
endmodule
